// ---- cms_consts.svh ----
// Register offsets, field positions, reset values and fixed codes.
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

`define NUM_REGS      16
`define REG_RESET     8'h00
`define I2C_ADDR_HI   4'ha

`define OFS_SWITCH    8'h00
`define OFS_LOOPBACK  8'h01
`define OFS_EQ_A      8'h02
`define OFS_EQ_B      8'h03
`define OFS_EQ_C      8'h04
`define OFS_PE_A      8'h05
`define OFS_PE_B      8'h06
`define OFS_PE_C      8'h07
`define OFS_LEVEL     8'h08
`define OFS_RXOPT     8'h09
`define OFS_MODE      8'h0f

`define SW_SEL_MSB    3
`define SW_SEL_LSB    0
`define SW_BICAST     4
`define SW_SPEED      5
`define LB_MSB        6
`define LB_LSB        4
`define EQ_MSB        3
`define PE_MSB        2
`define LVL_MSB       5
`define SWAP_MSB      2
`define SQ_MSB        6
`define SQ_LSB        4
`define MODE_MSB      1

`define MODE_PIN      2'h0
`define MODE_ALT_PIN  2'h1
`define MODE_MIXED    2'h2
`define MODE_SERIAL   2'h3

`define EQ_PIN_L0     4'h0
`define EQ_PIN_L1     4'h3
`define EQ_PIN_L2     4'h6
`define EQ_PIN_L3     4'h9
`define PE_PIN_OFF    3'h0
`define PE_PIN_ON     3'h7
`define LVL_400MV     2'h2
`define SQ_PIN_ALL    3'h7
`define SWAP_PIN_NONE 3'h0

`endif

// ---- cms_pkg.sv ----
// Types shared by the control mode select block.
`include "cms_consts.svh"
package cms_pkg;
    typedef logic [`NUM_REGS-1:0][7:0] regimg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_OFS,
        ST_WR,
        ST_ACK,
        ST_RD,
        ST_MACK,
        ST_RLOAD
    } i2c_state_e;

    typedef struct packed {
        logic [3:0] lane_sel;
        logic       bicast;
        logic [2:0] loopback;
        logic       speed_4g;
        logic [3:0] eq_a;
        logic [3:0] eq_b;
        logic [3:0] eq_c;
        logic [2:0] pe_a;
        logic [2:0] pe_b;
        logic [2:0] pe_c;
        logic [5:0] level;
        logic [2:0] pn_swap;
        logic [2:0] squelch;
        logic [1:0] mode;
    } ctl_s;
endpackage

// ---- cms_regbank_if.sv ----
// Carrier between the bus target logic and the register memory.
`timescale 1ns/1ps
`default_nettype none
interface cms_regbank_if;
    logic                  we;
    logic [3:0]            waddr;
    logic [7:0]            wdata;
    logic [3:0]            raddr;
    logic [7:0]            rdata;
    cms_pkg::regimg_t      image;

    modport owner (input we, input waddr, input wdata, input raddr,
                   output rdata, output image);
    modport user  (output we, output waddr, output wdata, output raddr,
                   input rdata, input image);
endinterface
`default_nettype wire

// ---- cms_regfile.sv ----
// Register memory with a registered read port and a full image output.
`timescale 1ns/1ps
`default_nettype none
`include "cms_consts.svh"
module cms_regfile (
    input  wire logic    clk,   // system clock
    input  wire logic    rstn,  // synchronous reset, active low
    cms_regbank_if.owner bank   // access port
);
    cms_pkg::regimg_t mem_r;
    logic [7:0]       rdata_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_r   <= {`NUM_REGS{`REG_RESET}};
            rdata_r <= `REG_RESET;
        end else begin
            if (bank.we) begin
                mem_r[bank.waddr] <= bank.wdata;
            end
            rdata_r <= mem_r[bank.raddr];
        end
    end

    assign bank.rdata = rdata_r;
    assign bank.image = mem_r;
endmodule
`default_nettype wire

// ---- control_mode_select.sv ----
// Control source selection with its two-wire serial register target.
`timescale 1ns/1ps
`default_nettype none
`include "cms_consts.svh"
module control_mode_select (
    input  wire logic       CLK,           // 125 MHz system clock
    input  wire logic       RSTN,          // chip reset, active low
    input  wire logic       SCL,           // serial clock pin
    input  wire logic       SDA_I,         // serial data pin level
    output logic            SDA_O,         // serial data drive value
    output logic            SDA_OE,        // serial data drive enable
    input  wire logic [2:0] ADDR_PINS,     // target address straps
    input  wire logic [3:0] SEL_PINS,      // lane A/B select pins
    input  wire logic       BICAST_PIN,    // bicast enable pin
    input  wire logic [2:0] LOOPBACK_PINS, // port loopback pins C,B,A
    input  wire logic       SPEED_PIN,     // low speed PE select pin
    input  wire logic [5:0] EQ_PINS,       // EQ pins {C,B,A} x 2
    input  wire logic [2:0] PE_PINS,       // PE pins C,B,A
    output logic [3:0]      LANE_SEL,      // active lane select
    output logic            BICAST,        // active bicast enable
    output logic [2:0]      PORT_LOOPBACK, // active loopback C,B,A
    output logic            SPEED_4G,      // active low speed PE
    output logic [3:0]      EQ_A,          // port A equalizer code
    output logic [3:0]      EQ_B,          // port B equalizer code
    output logic [3:0]      EQ_C,          // port C equalizer code
    output logic [2:0]      PE_A,          // port A pre-emphasis code
    output logic [2:0]      PE_B,          // port B pre-emphasis code
    output logic [2:0]      PE_C,          // port C pre-emphasis code
    output logic [5:0]      OUT_LEVEL,     // output level {C,B,A} x 2
    output logic [2:0]      PN_SWAP,       // input polarity swap C,B,A
    output logic [2:0]      SQUELCH_EN,    // squelch enable C,B,A
    output logic [1:0]      MODE           // active control mode
);
    localparam int NPIN = 23;

    cms_regbank_if bank ();

    logic [NPIN-1:0]     s1_r;
    logic [NPIN-1:0]     s2_r;
    logic [1:0]          prev_r;
    cms_pkg::i2c_state_e state_r;
    cms_pkg::i2c_state_e state_nxt;
    logic [2:0]          cnt_r;
    logic [2:0]          cnt_nxt;
    logic [7:0]          sh_r;
    logic [7:0]          sh_nxt;
    logic [7:0]          tx_r;
    logic [7:0]          tx_nxt;
    logic [7:0]          ptr_r;
    logic [7:0]          ptr_nxt;
    logic                ack_r;
    logic                ack_nxt;
    logic                rw_r;
    logic                rw_nxt;
    logic                ofs_r;
    logic                ofs_nxt;
    logic                wr_en;
    cms_pkg::ctl_s       ctl_r;
    cms_pkg::ctl_s       ctl_nxt;

    function automatic logic [3:0] eq_pin_code(input logic [1:0] p);
        case (p)
            2'h0:    eq_pin_code = `EQ_PIN_L0;
            2'h1:    eq_pin_code = `EQ_PIN_L1;
            2'h2:    eq_pin_code = `EQ_PIN_L2;
            default: eq_pin_code = `EQ_PIN_L3;
        endcase
    endfunction

    cms_regfile u_regs (
        .clk  (CLK),
        .rstn (RSTN),
        .bank (bank)
    );

    wire [NPIN-1:0] pins_raw = {SCL, SDA_I, ADDR_PINS, SEL_PINS, BICAST_PIN,
                                LOOPBACK_PINS, SPEED_PIN, EQ_PINS, PE_PINS};
    wire       scl_s     = s2_r[22];
    wire       sda_s     = s2_r[21];
    wire [2:0] addr_s    = s2_r[20:18];
    wire [3:0] sel_s     = s2_r[17:14];
    wire       bicast_s  = s2_r[13];
    wire [2:0] lb_s      = s2_r[12:10];
    wire       speed_s   = s2_r[9];
    wire [5:0] eq_s      = s2_r[8:3];
    wire [2:0] pe_s      = s2_r[2:0];
    wire       scl_rise  = scl_s & ~prev_r[1];
    wire       scl_fall  = ~scl_s & prev_r[1];
    wire       start_ev  = scl_s & prev_r[1] & ~sda_s & prev_r[0];
    wire       stop_ev   = scl_s & prev_r[1] & sda_s & ~prev_r[0];
    wire [7:0] byte_in   = {sh_r[6:0], sda_s};
    wire       in_range  = (ptr_r[7:4] == 4'h0);
    wire       addr_hit  = (byte_in[7:1] == {`I2C_ADDR_HI, addr_s});

    // Pins are synchronised before use; SCL and SDA keep one more stage.
    // Bus lines reset to their released level, so no false edge follows.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s1_r   <= {2'h3, {(NPIN-2){1'b0}}};
            s2_r   <= {2'h3, {(NPIN-2){1'b0}}};
            prev_r <= 2'h3;
        end else begin
            s1_r   <= pins_raw;
            s2_r   <= s1_r;
            prev_r <= {scl_s, sda_s};
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        ack_nxt   = ack_r;
        rw_nxt    = rw_r;
        ofs_nxt   = ofs_r;
        wr_en     = 1'b0;
        if (stop_ev) begin
            state_nxt = cms_pkg::ST_IDLE;
            ack_nxt   = 1'b0;
        end else if (start_ev) begin
            state_nxt = cms_pkg::ST_ADDR;
            cnt_nxt   = 3'h0;
            ack_nxt   = 1'b0;
            ofs_nxt   = 1'b0;
        end else begin
            case (state_r)
                cms_pkg::ST_IDLE: begin
                end
                cms_pkg::ST_ADDR, cms_pkg::ST_OFS, cms_pkg::ST_WR: begin
                    if (scl_rise) begin
                        sh_nxt  = byte_in;
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            state_nxt = cms_pkg::ST_ACK;
                            if (state_r == cms_pkg::ST_ADDR) begin
                                rw_nxt = byte_in[0];
                                if (!addr_hit) begin
                                    state_nxt = cms_pkg::ST_IDLE;
                                end
                            end else if (state_r == cms_pkg::ST_OFS) begin
                                ptr_nxt = byte_in;
                                ofs_nxt = 1'b1;
                            end else begin
                                wr_en   = 1'b1;
                                ptr_nxt = ptr_r + 8'h01;
                            end
                        end
                    end
                end
                cms_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        ack_nxt = ~ack_r;
                        if (ack_r && rw_r) begin
                            tx_nxt    = in_range ? bank.rdata : 8'h00;
                            ptr_nxt   = ptr_r + 8'h01;
                            cnt_nxt   = 3'h0;
                            state_nxt = cms_pkg::ST_RD;
                        end else if (ack_r) begin
                            cnt_nxt   = 3'h0;
                            state_nxt = ofs_r ? cms_pkg::ST_WR
                                              : cms_pkg::ST_OFS;
                        end
                    end
                end
                cms_pkg::ST_RD: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 3'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == 3'h0) begin
                            state_nxt = cms_pkg::ST_MACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                        end
                    end
                end
                cms_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        state_nxt = sda_s ? cms_pkg::ST_IDLE
                                          : cms_pkg::ST_RLOAD;
                    end
                end
                cms_pkg::ST_RLOAD: begin
                    if (scl_fall) begin
                        tx_nxt    = in_range ? bank.rdata : 8'h00;
                        ptr_nxt   = ptr_r + 8'h01;
                        cnt_nxt   = 3'h0;
                        state_nxt = cms_pkg::ST_RD;
                    end
                end
                default: state_nxt = cms_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_r <= cms_pkg::ST_IDLE;
            cnt_r   <= 3'h0;
            sh_r    <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= 8'h00;
            ack_r   <= 1'b0;
            rw_r    <= 1'b0;
            ofs_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            ack_r   <= ack_nxt;
            rw_r    <= rw_nxt;
            ofs_r   <= ofs_nxt;
        end
    end

    // Reserved mode bits are stored as zero; unmapped offsets are dropped.
    assign bank.we    = wr_en & in_range;
    assign bank.waddr = ptr_r[3:0];
    assign bank.wdata = (ptr_r == `OFS_MODE) ? {6'h00, byte_in[1:0]}
                                              : byte_in;
    assign bank.raddr = ptr_r[3:0];
    assign SDA_O      = 1'b0;
    assign SDA_OE     = ack_r | ((state_r == cms_pkg::ST_RD) & ~tx_r[7]);

    wire [7:0] r_sw  = bank.image[`OFS_SWITCH];
    wire [7:0] r_opt = bank.image[`OFS_RXOPT];
    wire [1:0] mode  = bank.image[`OFS_MODE][`MODE_MSB:0];
    // Serial mode ignores the control pins.
    // Serial mode takes switch settings too.
    wire       reg_sw = (mode == `MODE_SERIAL);
    // Mixed or serial take the analog settings.
    // Mode 01 falls through to pin control.
    wire       reg_fx = (mode == `MODE_MIXED) | (mode == `MODE_SERIAL);

    assign ctl_nxt.lane_sel = reg_sw ? r_sw[`SW_SEL_MSB:`SW_SEL_LSB] : sel_s;
    assign ctl_nxt.bicast   = reg_sw ? r_sw[`SW_BICAST] : bicast_s;
    assign ctl_nxt.loopback = reg_sw ?
                              bank.image[`OFS_LOOPBACK][`LB_MSB:`LB_LSB] : lb_s;
    assign ctl_nxt.speed_4g = reg_sw ? r_sw[`SW_SPEED] : speed_s;
    assign ctl_nxt.eq_a = reg_fx ? bank.image[`OFS_EQ_A][`EQ_MSB:0]
                                 : eq_pin_code(eq_s[1:0]);
    assign ctl_nxt.eq_b = reg_fx ? bank.image[`OFS_EQ_B][`EQ_MSB:0]
                                 : eq_pin_code(eq_s[3:2]);
    assign ctl_nxt.eq_c = reg_fx ? bank.image[`OFS_EQ_C][`EQ_MSB:0]
                                 : eq_pin_code(eq_s[5:4]);
    assign ctl_nxt.pe_a = reg_fx ? bank.image[`OFS_PE_A][`PE_MSB:0]
                                 : (pe_s[0] ? `PE_PIN_ON : `PE_PIN_OFF);
    assign ctl_nxt.pe_b = reg_fx ? bank.image[`OFS_PE_B][`PE_MSB:0]
                                 : (pe_s[1] ? `PE_PIN_ON : `PE_PIN_OFF);
    assign ctl_nxt.pe_c = reg_fx ? bank.image[`OFS_PE_C][`PE_MSB:0]
                                 : (pe_s[2] ? `PE_PIN_ON : `PE_PIN_OFF);
    assign ctl_nxt.level = reg_fx ? bank.image[`OFS_LEVEL][`LVL_MSB:0]
                                  : {3{`LVL_400MV}};
    assign ctl_nxt.pn_swap = reg_fx ? r_opt[`SWAP_MSB:0] : `SWAP_PIN_NONE;
    assign ctl_nxt.squelch = reg_fx ? r_opt[`SQ_MSB:`SQ_LSB] : `SQ_PIN_ALL;
    assign ctl_nxt.mode    = mode;

    // Reset clears every output to zero; pin-mode values load on the first cycle after reset.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign LANE_SEL      = ctl_r.lane_sel;
    assign BICAST        = ctl_r.bicast;
    assign PORT_LOOPBACK = ctl_r.loopback;
    assign SPEED_4G      = ctl_r.speed_4g;
    assign EQ_A          = ctl_r.eq_a;
    assign EQ_B          = ctl_r.eq_b;
    assign EQ_C          = ctl_r.eq_c;
    assign PE_A          = ctl_r.pe_a;
    assign PE_B          = ctl_r.pe_b;
    assign PE_C          = ctl_r.pe_c;
    assign OUT_LEVEL     = ctl_r.level;
    assign PN_SWAP       = ctl_r.pn_swap;
    assign SQUELCH_EN    = ctl_r.squelch;
    assign MODE          = ctl_r.mode;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_reset_pin_mode: assert property (
        @(posedge CLK) $past(!RSTN) |-> (MODE == `MODE_PIN) &&
        (PE_A == `PE_PIN_OFF))
        else $error("mode not pin control after reset");
    chk_reset_regs: assert property (
        @(posedge CLK) $past(!RSTN) |-> (bank.image == '0))
        else $error("registers not cleared by reset");
    chk_pin_eq: assert property (
        !reg_fx ##1 !reg_fx |-> EQ_B == eq_pin_code($past(eq_s[3:2])))
        else $error("pin mode EQ not from pins");
    chk_mixed_switch: assert property (
        (mode == `MODE_MIXED) |=>
        (LANE_SEL == $past(sel_s)) && (PORT_LOOPBACK == $past(lb_s)))
        else $error("mixed mode switch not from pins");
    chk_mixed_regs: assert property (
        (mode == `MODE_MIXED) |=>
        EQ_A == $past(bank.image[`OFS_EQ_A][3:0]))
        else $error("mixed mode EQ not from register");
    chk_serial_regs: assert property (
        (mode == `MODE_SERIAL) |=> (LANE_SEL == $past(r_sw[3:0])) &&
        (PE_C == $past(bank.image[`OFS_PE_C][2:0])))
        else $error("serial mode not from registers");
    chk_serial_loopback: assert property (
        (mode == `MODE_SERIAL) |=>
        PORT_LOOPBACK == $past(bank.image[`OFS_LOOPBACK][6:4]))
        else $error("serial loopback not from register");
    chk_target_drive: assert property (
        SDA_OE |-> (state_r == cms_pkg::ST_ACK) ||
                   (state_r == cms_pkg::ST_RD))
        else $error("data line driven outside target phases");
    chk_addr_miss: assert property (
        (state_r == cms_pkg::ST_ADDR) && scl_rise && (cnt_r == 3'h7) &&
        !start_ev && !stop_ev && (byte_in[7:4] != `I2C_ADDR_HI)
        |=> (state_r == cms_pkg::ST_IDLE))
        else $error("foreign address was accepted");
    chk_pin_features: assert property (
        (mode == `MODE_ALT_PIN) |=> (SQUELCH_EN == 3'h7) &&
        (PN_SWAP == 3'h0) && (OUT_LEVEL == 6'h2a))
        else $error("pin mode feature subset wrong");
    chk_mode_reserved: assert property (
        bank.image[`OFS_MODE][7:2] == 6'h00)
        else $error("reserved mode bits not zero");

    cov_mixed: cover property ((mode != `MODE_MIXED) ##1 (mode == `MODE_MIXED));
    cov_serial: cover property (mode == `MODE_SERIAL);
    cov_write: cover property (bank.we);
    cov_read: cover property (state_r == cms_pkg::ST_MACK);
endmodule
`default_nettype wire

// ---- serial_host.sv ----
// Two-wire serial bus controller model that reaches the device registers.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic clk,      // system clock
    input  wire logic sda_in,   // resolved data line level
    output logic      scl,      // serial clock line
    output logic      sda_pull  // high while pulling the data line low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic half();
        repeat (6) @(posedge clk);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    // One clocked bit; the data line moves only while the clock is low.
    task automatic clk_bit(input logic b, output logic s);
        sda_pull <= ~b;
        half();
        scl <= 1'b1;
        half();
        s = sda_in;
        scl <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(nack, s);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the control mode select block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [8:0]  sw;
        logic [5:0]  eq;
        logic [2:0]  pe;
        logic [11:0] eq_exp;
        logic [8:0]  pe_exp;
    } row_s;
    localparam logic [2:0]  STRAP = 3'h5;
    localparam logic [7:0]  DEV_W = {4'ha, STRAP, 1'b0};
    localparam logic [11:0] PIN_MISC = {6'h2a, 3'h0, 3'h7};
    localparam logic [8:0]  REG_SW = 9'h0a7;
    localparam logic [8:0]  REG_PE = {3'h5, 3'h4, 3'h3};
    localparam logic [11:0] REG_MISC = {6'h1b, 3'h5, 3'h3};
    localparam row_s ROWS [4] = '{
        '{9'h000, 6'h00, 3'h0, 12'h000, 9'h000},
        '{9'h1ff, 6'h3f, 3'h7, 12'h999, 9'h1ff},
        '{9'h0a5, 6'h39, 3'h5, 12'h369, 9'h1c7},
        '{9'h15a, 6'h06, 3'h2, 12'h630, 9'h038}};
    localparam logic [7:0] BAD [2] = '{8'hba, 8'ha8};
    localparam logic [7:0] REGV [10] = '{8'h25, 8'h30, 8'h0c, 8'h0d,
        8'h0e, 8'h05, 8'h04, 8'h03, 8'h1b, 8'h35};
    localparam logic [7:0] MODES [3] = '{8'h01, 8'hfe, 8'hff};
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  strap = STRAP;
    logic [8:0]  sw = 9'h000;
    logic [5:0]  eq_p = 6'h00;
    logic [2:0]  pe_p = 3'h0;
    wire         scl;
    wire         pull;
    logic        sda_o;
    logic        sda_oe;
    logic [3:0]  lane_sel;
    logic        bicast;
    logic [2:0]  lpbk;
    logic        spd4g;
    logic [3:0]  eq_a, eq_b, eq_c;
    logic [2:0]  pe_a, pe_b, pe_c;
    logic [5:0]  lvl;
    logic [2:0]  swap, sq;
    logic [1:0]  mode, m;
    logic [7:0]  v;
    logic [8:0]  es, ep;
    logic [11:0] ee, em;
    int          err_total = 0;
    int          check_count = 0;
    wire         sda = ~(pull | sda_oe);
    wire [8:0]   sw_o = {lane_sel, bicast, lpbk, spd4g};
    always #4 clk = ~clk;
    serial_host serial_host_i (.clk(clk), .sda_in(sda), .scl(scl),
        .sda_pull(pull));
    control_mode_select control_mode_select_i (
        .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .ADDR_PINS(strap), .SEL_PINS(sw[8:5]),
        .BICAST_PIN(sw[4]), .LOOPBACK_PINS(sw[3:1]), .SPEED_PIN(sw[0]),
        .EQ_PINS(eq_p), .PE_PINS(pe_p), .LANE_SEL(lane_sel),
        .BICAST(bicast), .PORT_LOOPBACK(lpbk), .SPEED_4G(spd4g),
        .EQ_A(eq_a), .EQ_B(eq_b), .EQ_C(eq_c), .PE_A(pe_a), .PE_B(pe_b),
        .PE_C(pe_c), .OUT_LEVEL(lvl), .PN_SWAP(swap), .SQUELCH_EN(sq),
        .MODE(mode));
    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic outs(input logic [8:0] s, input logic [11:0] e,
                        input logic [8:0] p, input logic [11:0] x);
        chk("switch", 12'(sw_o), 12'(s));
        chk("eq", {eq_a, eq_b, eq_c}, e);
        chk("pe", 12'({pe_a, pe_b, pe_c}), 12'(p));
        chk("level swap squelch", {lvl, swap, sq}, x);
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b, input logic want);
        logic a;
        serial_host_i.wbyte(b, a);
        chk("ack", 12'(a), 12'(want));
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        serial_host_i.start();
        send(DEV_W, 1'b1);
        send(ofs, 1'b1);
        send(d, 1'b1);
        serial_host_i.stop();
        settle();
    endtask
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        serial_host_i.start();
        send(DEV_W, 1'b1);
        send(ofs, 1'b1);
        serial_host_i.start();
        send(DEV_W | 8'h01, 1'b1);
        serial_host_i.rbyte(1'b1, d);
        serial_host_i.stop();
        settle();
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        settle();
        outs(9'h000, 12'h000, 9'h000, PIN_MISC);
        chk("mode", 12'(mode), 12'h000);
        chk("data drive", 12'(sda_o), 12'h000);
        foreach (ROWS[i]) begin
            sw <= ROWS[i].sw;
            eq_p <= ROWS[i].eq;
            pe_p <= ROWS[i].pe;
            settle();
            outs(ROWS[i].sw, ROWS[i].eq_exp, ROWS[i].pe_exp, PIN_MISC);
        end
        foreach (BAD[i]) begin
            serial_host_i.start();
            send(BAD[i], 1'b0);
            serial_host_i.stop();
        end
        serial_host_i.start();
        send(DEV_W, 1'b1);
        send(8'h00, 1'b1);
        foreach (REGV[i]) begin
            send(REGV[i], 1'b1);
        end
        serial_host_i.stop();
        settle();
        outs(9'h15a, 12'h630, 9'h038, PIN_MISC);
        wr(8'h1f, 8'h77);
        rd(8'h1f, v);
        chk("unmapped read", 12'(v), 12'h000);
        foreach (MODES[i]) begin
            m = MODES[i][1:0];
            wr(8'h0f, MODES[i]);
            rd(8'h0f, v);
            chk("mode reg", 12'(v), 12'(m));
            es = (m == 2'h3) ? REG_SW : 9'h15a;
            ee = m[1] ? 12'hcde : 12'h630;
            ep = m[1] ? REG_PE : 9'h038;
            em = m[1] ? REG_MISC : PIN_MISC;
            outs(es, ee, ep, em);
            chk("mode", 12'(mode), 12'(m));
        end
        sw <= 9'h000;
        eq_p <= 6'h00;
        pe_p <= 3'h0;
        settle();
        outs(REG_SW, 12'hcde, REG_PE, REG_MISC);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        settle();
        rd(8'h0f, v);
        chk("mode reg", 12'(v), 12'h000);
        rd(8'h02, v);
        chk("eq reg", 12'(v), 12'h000);
        outs(9'h000, 12'h000, 9'h000, PIN_MISC);
        strap <= 3'h2;
        settle();
        serial_host_i.start();
        send(DEV_W, 1'b0);
        serial_host_i.start();
        send({4'ha, 3'h2, 1'b0}, 1'b1);
        serial_host_i.stop();
        settle();
        tally_and_finish();
    end
endmodule
`default_nettype wire
